// File: hw/egress_cfg_pkg.sv
/*
 * egress_cfg_pkg: constants and types for the egress tagging and
 * host-port egress rate configuration block.
 * assumes: 32-bit apb, register indices scaled by four to byte addresses.
 */
package egress_cfg_pkg;

    // ==========================================================
    // register map (indices; byte address is index times four)
    localparam logic [15:0] IDX_TAG_RULES = 16'h1C0C;
    localparam logic [15:0] IDX_RATE_LOW = 16'h1C0D;
    localparam logic [15:0] IDX_RATE_HIGH = 16'h1C0E;
    localparam int ADDR_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_TAG_RULES = ADDR_W'({IDX_TAG_RULES, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_RATE_LOW = ADDR_W'({IDX_RATE_LOW, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_RATE_HIGH = ADDR_W'({IDX_RATE_HIGH, 2'b00});

    // ==========================================================
    // tagging rules layout
    localparam logic [31:0] TAG_RULES_MASK = 32'h003F3F3F;
    localparam logic [31:0] TAG_RULES_RESET = 32'h00000000;
    localparam int PORT_FIELD_STRIDE = 8;
    localparam int NUM_PORTS = 3;

    // ==========================================================
    // rate layout
    localparam int RATE_W = 13;
    localparam int RATE_HI_LSB = 13;
    localparam logic [31:0] RATE_MASK = 32'h03FFFFFF;
    localparam logic [31:0] RATE_RESET = 32'h00000000;
    localparam int NUM_QUEUES = 4;
    localparam int RATE_UNIT_NS = 20;
    localparam int CLK_PERIOD_NS = 10;
    localparam int RATE_UNIT_CYC = (RATE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // egress port types
    typedef enum logic [1:0]
    {
        PT_PASS = 2'h0,
        PT_ACCESS = 2'h1,
        PT_HYBRID = 2'h2,
        PT_HOST = 2'h3
    } port_type_t;

    typedef struct packed
    {
        logic insert_tag;
        logic change_vid;
        logic change_prio;
        logic change_tag;
        port_type_t ptype;
    } port_ctl_t;

    // per-frame context from the forwarding datapath
    typedef struct packed
    {
        logic is_tagged;
        logic is_prio_tagged;
        logic is_special;
        logic from_host;
        logic untag_default;
        logic untag_incoming;
        logic [1:0] src_port;
    } frame_info_t;

    // edit decision handed back to the datapath
    typedef struct packed
    {
        logic strip;
        logic insert;
        logic add_special;
        logic vid_from_egress;
        logic vid_from_ingress;
        logic prio_from_egress;
        logic [1:0] special_src;
    } edit_t;

endpackage

// File: hw/egress_tag_and_rate_config.sv
/*
 * egress_tag_and_rate_config: apb register bank holding egress tagging
 * rules for three ports and host-port egress byte rates, with a per-port
 * tag edit decision and per-queue byte spacing pacers.
 * assumes: one clock pclk at 100 MHz; frame_start/byte_sent come from
 * logic on the same clock.
 */
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps

// Functional notes
// - pass-through type (00, bits 17:16 for port 2) keeps regular frames, strips host special tags.
// - access type strips the tag of every tagged frame, special tagged ones included.
// - hybrid type inserts or changes tags as the port's insert and change bits say; it strips special tags and tags untagged in the table.
// - host-processor type adds a special tag naming the ingress port.
// - every egress type field resets to zero, i.e. pass-through.
// - port 1 has insert tag at bit 13 and egress type at bits 9:8, coded like port 2.
// - port 1 has change vid at bit 12, change priority at bit 11, change tag at bit 10.
// - host port has insert 5, change vid 4, change priority 3, change tag 2, type 1:0.
// - each queue's bytes are spaced by (rate value + 1) times 20 ns.
// - host queue 1 rate sits at bits 25:13 and queue 0 at 12:0 of one register, reset zero.
// - host queues 3 and 2 sit likewise in a second register, bits 31:26 read-only zero.
// - hybrid insert adds the ingress default tag to untagged frames if default vid untag is clear.
// - hybrid change vid with change tag uses egress default vid; priority tagged use ingress vid.
// - hybrid change priority with change tag uses egress default priority unless untagged in table.
// - change tag gates change vid and change priority for regular tagged frames only.
module egress_tag_and_rate_config
    import egress_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_PORTS-1:0] frame_start,
    input frame_info_t frame_info [NUM_PORTS],
    output edit_t frame_edit [NUM_PORTS],
    input wire logic [NUM_QUEUES-1:0] byte_sent,
    output logic [NUM_QUEUES-1:0] queue_ready
);

    // ==========================================================
    // apb slave
    logic [31:0] tag_rules_r;
    logic [31:0] rate_low_r;
    logic [31:0] rate_high_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    wire access_w = psel & penable;
    wire hit_tag = (paddr == ADDR_TAG_RULES);
    wire hit_low = (paddr == ADDR_RATE_LOW);
    wire hit_high = (paddr == ADDR_RATE_HIGH);
    wire hit_any = hit_tag | hit_low | hit_high;
    wire wr_tag = access_w & pwrite & hit_tag;
    wire wr_low = access_w & pwrite & hit_low;
    wire wr_high = access_w & pwrite & hit_high;
    wire [31:0] rd_mux = hit_tag ? tag_rules_r :
                         hit_low ? rate_low_r :
                         hit_high ? rate_high_r : 32'h00000000;

    // zero wait state: read data is registered in the setup cycle
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tag_rules_r <= TAG_RULES_RESET;
            rate_low_r <= RATE_RESET;
            rate_high_r <= RATE_RESET;
        end
        else
        begin
            if (wr_tag)
                tag_rules_r <= merge(tag_rules_r, pwdata, pstrb, TAG_RULES_MASK);
            if (wr_low)
                rate_low_r <= merge(rate_low_r, pwdata, pstrb, RATE_MASK);
            if (wr_high)
                rate_high_r <= merge(rate_high_r, pwdata, pstrb, RATE_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end
        else if (psel & ~penable)
        begin
            prdata_r <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_r <= ~hit_any;
        end
    end

    // ==========================================================
    // per-port tag edit decision
    function automatic edit_t decide(input port_ctl_t c, input frame_info_t f);
        edit_t e;
        logic regular;
        e = '0;
        regular = f.is_tagged & ~f.is_prio_tagged;
        unique case (c.ptype)
            PT_PASS:
            begin
                e.strip = f.is_special & f.from_host;
            end
            PT_ACCESS:
            begin
                e.strip = f.is_tagged | f.is_special;
            end
            PT_HYBRID:
            begin
                e.strip = f.is_special;
                e.insert = ~f.is_tagged & c.insert_tag & ~f.untag_default;
                if (regular & f.untag_incoming)
                    e.strip = 1'b1;
                e.vid_from_egress = regular & c.change_tag & c.change_vid
                                    & ~f.untag_incoming;
                e.prio_from_egress = regular & c.change_tag & c.change_prio
                                     & ~f.untag_incoming;
                e.vid_from_ingress = f.is_prio_tagged;
            end
            PT_HOST:
            begin
                e.add_special = 1'b1;
                e.special_src = f.src_port;
            end
        endcase
        return e;
    endfunction

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++)
        begin : g_port
            wire port_ctl_t ctl_w = port_ctl_t'(tag_rules_r[gp*PORT_FIELD_STRIDE +: 6]);
            edit_t edit_r;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    edit_r <= '0;
                else if (frame_start[gp])
                    edit_r <= decide(ctl_w, frame_info[gp]);
            end
            assign frame_edit[gp] = edit_r;
        end
    endgenerate

    // ==========================================================
    // host port byte pacers
    localparam int CNT_W = RATE_W + 2;
    wire [RATE_W-1:0] rate_val [NUM_QUEUES];
    assign rate_val[0] = rate_low_r[RATE_W-1:0];
    assign rate_val[1] = rate_low_r[RATE_HI_LSB +: RATE_W];
    assign rate_val[2] = rate_high_r[RATE_W-1:0];
    assign rate_val[3] = rate_high_r[RATE_HI_LSB +: RATE_W];

    genvar gq;
    generate
        for (gq = 0; gq < NUM_QUEUES; gq++)
        begin : g_queue
            logic [CNT_W-1:0] wait_r;
            // reload spans the whole gap after the byte already sent; latched per byte
            wire [CNT_W-1:0] gap_w = CNT_W'((({2'b00, rate_val[gq]} + 1'b1) * RATE_UNIT_CYC) - 1);
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    wait_r <= '0;
                else if (byte_sent[gq] && wait_r == '0)
                    wait_r <= gap_w;
                else if (wait_r != '0)
                    wait_r <= wait_r - 1'b1;
            end
            assign queue_ready[gq] = (wait_r == '0);
        end
    endgenerate

endmodule

// File: verification/egress_cfg_properties.sv
/* egress_cfg_properties: port assertions for egress_tag_and_rate_config.
   assumes: bound to that block; shadows follow its apb writes. */
`timescale 1ns/100ps
module egress_cfg_properties
    import egress_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_PORTS-1:0] frame_start,
    input wire frame_info_t frame_info [NUM_PORTS],
    input wire edit_t frame_edit [NUM_PORTS],
    input wire logic [NUM_QUEUES-1:0] byte_sent,
    input wire logic [NUM_QUEUES-1:0] queue_ready
);
    // ==========
    // shadows: tag rules, rate low, rate high; byte lanes kept apart
    logic [31:0] sh [3];
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            sh <= '{default: 32'h0};
        else if (psel && penable && pwrite)
            for (int i = 0; i < 3; i++)
                for (int b = 0; b < 4; b++)
                    if (paddr == ADDR_TAG_RULES + 16'(4 * i) && pstrb[b])
                        sh[i][8*b+:8] <= pwdata[8*b+:8];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // edits use the rules as they stood at frame start
    pass_keep_a: assert property (frame_start[2] && sh[0][17:16] == 2'h0 &&
        !frame_info[2].is_special |=> !frame_edit[2].strip && !frame_edit[2].insert)
        else $error("pass frame edited");
    access_strip_a: assert property (frame_start[1] && sh[0][9:8] == 2'h1 &&
        frame_info[1].is_tagged |=> frame_edit[1].strip) else $error("access tag kept");
    host_tag_a: assert property (frame_start[0] && sh[0][1:0] == 2'h3 |=>
        frame_edit[0].add_special && frame_edit[0].special_src == $past(frame_info[0].src_port))
        else $error("special tag wrong");
    hold_edit_a: assert property (!frame_start[0] |=> $stable(frame_edit[0]))
        else $error("edit changed mid frame");
    pace_zero_a: assert property (byte_sent[0] && queue_ready[0] && sh[1][12:0] == 13'h0
        |=> !queue_ready[0] ##1 queue_ready[0]) else $error("queue 0 gap");
    pace_one_a: assert property (byte_sent[1] && queue_ready[1] && sh[1][25:13] == 13'h1
        |=> !queue_ready[1] [*3] ##1 queue_ready[1]) else $error("queue 1 gap");
    pace_three_a: assert property (byte_sent[3] && queue_ready[3] && sh[2][25:13] == 13'h2
        |=> !queue_ready[3] [*5] ##1 queue_ready[3]) else $error("queue 3 gap");
    tag_readback_a: assert property (psel && penable && !pwrite && paddr == ADDR_TAG_RULES
        |-> prdata == (sh[0] & 32'h003F3F3F)) else $error("tag rules readback");
    cover property (frame_start[2] && sh[0][17:16] == 2'h2);
    cover property (byte_sent[3] && queue_ready[3]);
    cover property (psel && penable && pslverr);
endmodule
bind egress_tag_and_rate_config egress_cfg_properties props (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .frame_start, .frame_info,
    .frame_edit, .byte_sent, .queue_ready);

// File: verification/tb_egress_tag_and_rate_config.sv
/* tb_egress_tag_and_rate_config: apb registers, frame edits, byte pacing.
   assumes: pclk 100 MHz; full-word writes only. */
`timescale 1ns/100ps
module tb_egress_tag_and_rate_config
    import egress_cfg_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, e;
    logic [NUM_PORTS-1:0] frame_start = 3'h0;
    logic [NUM_QUEUES-1:0] byte_sent = 4'h0, queue_ready;
    frame_info_t frame_info [NUM_PORTS] = '{default: 8'h0};
    edit_t frame_edit [NUM_PORTS];
    edit_t ed;
    int failures = 0, n_tests = 0;
    // frame table: port, info, mask, expected edit; rules switch at entry 4
    // last entry: hybrid regular tag whose incoming vlan is untagged is stripped, not changed
    int fp [11] = '{2, 2, 1, 0, 2, 2, 2, 1, 0, 0, 2};
    logic [7:0] fi [11] = '{8'h31, 8'h80, 8'h31, 8'h82, 8'h00, 8'h80, 8'h40, 8'h80, 8'h08, 8'h00,
        8'h84};
    logic [7:0] fm [11] = '{8'h80, 8'hC0, 8'h80, 8'h23, 8'h40, 8'h10, 8'h08, 8'h14, 8'h40, 8'h40,
        8'h90};
    logic [7:0] fx [11] = '{8'h80, 8'h00, 8'h80, 8'h22, 8'h40, 8'h10, 8'h08, 8'h04, 8'h00, 8'h40,
        8'h80};
    egress_tag_and_rate_config uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .frame_start, .frame_info, .frame_edit, .byte_sent,
        .queue_ready);
    initial
    begin
        forever #5 pclk = ~pclk;
    end
    // ==========
    // bus and port tasks
    task automatic chk(input logic [31:0] x, input logic [31:0] g, input string nm);
        n_tests++;
        if (g !== x)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0);
        chk(x, q, "rdata");
        chk({31'h0, xe}, {31'h0, e}, "slverr");
    endtask
    task automatic frm(input int p, input frame_info_t f);
        @(posedge pclk);
        frame_start[p] <= 1'b1;
        frame_info[p] <= f;
        @(posedge pclk);
        frame_start[p] <= 1'b0;
        @(posedge pclk);
        ed = frame_edit[p];
    endtask
    // gap counted in cycles from one accepted byte to the next ready
    task automatic pace(input int qi, input int x);
        int n = 0;
        @(posedge pclk);
        byte_sent[qi] <= 1'b1;
        @(posedge pclk);
        byte_sent[qi] <= 1'b0;
        do @(posedge pclk); while (queue_ready[qi] !== 1'b1 && ++n < 100);
        chk(32'(x), 32'(n + 1), "gap");
    endtask
    task automatic end_of_test();
        if (failures == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge pclk);
        failures++;
        end_of_test();
    end
    // ==========
    // main sequence
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_TAG_RULES, 32'h0, 1'b0);
        rd(ADDR_RATE_LOW, 32'h0, 1'b0);
        rd(ADDR_RATE_HIGH, 32'h0, 1'b0);
        rd(16'h703C, 32'h0, 1'b1);
        apb(1'b1, ADDR_TAG_RULES, 32'hFFFFFFFF);
        rd(ADDR_TAG_RULES, 32'h003F3F3F, 1'b0);
        apb(1'b1, ADDR_RATE_HIGH, 32'hFFFFFFFF);
        rd(ADDR_RATE_HIGH, 32'h03FFFFFF, 1'b0);
        apb(1'b1, ADDR_TAG_RULES, 32'h00000103);
        for (int i = 0; i < 11; i++)
        begin
            if (i == 4)
                apb(1'b1, ADDR_TAG_RULES, 32'h00360E22);
            frm(fp[i], fi[i]);
            chk(32'(fx[i]), 32'(ed & fm[i]), "edit");
        end
        apb(1'b1, ADDR_TAG_RULES, 32'h0);
        chk(32'h1, 32'(frame_edit[0].insert), "held edit");
        frm(0, 8'h00);
        chk(32'h0, 32'(ed.insert), "pass edit");
        apb(1'b1, ADDR_RATE_LOW, 32'h00002000);
        apb(1'b1, ADDR_RATE_HIGH, 32'h00004000);
        for (int k = 0; k < 4; k++)
            pace(k, (k == 1) ? 4 : ((k == 3) ? 6 : 2));
        end_of_test();
    end
endmodule
